// ---- hdl/dgcs_delay_timer.v ----
`timescale 1ns/1ps
// Counts reply delay in bit times after a read request frame ends
module dgcs_delay_timer #(
  parameter CW = 8
) (
  input wire clk_in,
  input wire resetn_in,
  input wire bit_tick_in,
  input wire start_in,
  input wire [CW-1:0] bits_in,
  output wire busy_out,
  output reg done_out
);
  reg [CW-1:0] remaining;

  assign busy_out = (remaining != {CW{1'b0}});

  // Load on start, count bit ticks, pulse done at zero
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      remaining <= {CW{1'b0}};
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        remaining <= bits_in;
      end else if (busy_out && bit_tick_in) begin
        remaining <= remaining - {{(CW-1){1'b0}}, 1'b1};
        if (remaining == {{(CW-1){1'b0}}, 1'b1}) begin
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // dgcs_delay_timer

// ---- hdl/dgcs_regs.v ----
`timescale 1ns/1ps
`include "dgcs_map.vh"
module dgcs_regs (
  input wire clk_in,
  input wire resetn_in,
  input wire bit_tick_in,
  input wire frame_valid_in,
  input wire frame_write_in,
  input wire [6:0] frame_addr_in,
  input wire [31:0] frame_wdata_in,
  input wire frame_end_in,
  input wire [31:0] frame_rdata_unused_in,
  input wire drv_err_cond_in,
  input wire drv_shutdown_in,
  input wire pump_uv_in,
  input wire pdn_pin_in,
  input wire microstep_sel_a_in,
  input wire microstep_sel_b_in,
  input wire [1:0] mstep_reg_in,
  input wire [1:0] hold_current_in,
  input wire driver_enable_low_in,
  output reg [31:0] rdata_out,
  output wire reply_go_out,
  output wire reply_wait_out,
  output wire [9:0] global_config_out,
  output wire standstill_reduce_out,
  output wire [1:0] microstep_res_out,
  output wire step_filter_en_out,
  output wire test_route_out,
  output wire enable_pulldown_out,
  output wire [1:0] test_select_out,
  output wire driver_active_out,
  output wire [2:0] status_out,
  output wire [7:0] write_count_out
);
  ////////////////////////////////////////////////////////////
  // Storage
  reg [9:0] global_config_flags;
  reg [1:0] status_latched;
  reg [7:0] serial_write_counter;
  reg [3:0] reply_delay_config;
  reg pdn_meta, pdn_sync;
  reg msa_meta, msa_sync;
  reg msb_meta, msb_sync;
  reg den_meta, den_sync;
  reg uv_meta, uv_sync;
  reg err_meta, err_sync;
  reg shd_meta, shd_sync;
  reg [7:0] next_delay_bits;

  wire wr_ok = frame_valid_in && frame_write_in;
  wire rd_ok = frame_valid_in && !frame_write_in;

  // Reply delay in bit times from a delay code
  function [7:0] dgcs_delay_bits;
    input [3:0] code;
    begin
      // Odd multiple of eight bit times, code pairs share one length
      dgcs_delay_bits = {1'b0, code[3:1], 1'b1, 3'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pins and external conditions
  // Powerdown pin, idle low after reset
  // Only the second stage is read by logic
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pdn_meta <= 1'b0;
      pdn_sync <= 1'b0;
    end else begin
      pdn_meta <= pdn_pin_in;
      pdn_sync <= pdn_meta;
    end
  end

  // Microstep select pin a
  // Read only while the register source is off
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      msa_meta <= 1'b0;
      msa_sync <= 1'b0;
    end else begin
      msa_meta <= microstep_sel_a_in;
      msa_sync <= msa_meta;
    end
  end

  // Microstep select pin b
  // Read only while the register source is off
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      msb_meta <= 1'b0;
      msb_sync <= 1'b0;
    end else begin
      msb_meta <= microstep_sel_b_in;
      msb_sync <= msb_meta;
    end
  end

  // Driver enable pin, active low
  // Resets to disabled so the driver never runs during reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      den_meta <= 1'b1;
      den_sync <= 1'b1;
    end else begin
      den_meta <= driver_enable_low_in;
      den_sync <= den_meta;
    end
  end

  // Pump undervoltage level
  // Shown live in status, never latched
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= pump_uv_in;
      uv_sync <= uv_meta;
    end
  end

  // Error cause still present
  // Blocks the error flag clear while high
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_meta <= 1'b0;
      err_sync <= 1'b0;
    end else begin
      err_meta <= drv_err_cond_in;
      err_sync <= err_meta;
    end
  end

  // Driver shutdown event level
  // Sets the error flag for as long as it stands
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shd_meta <= 1'b0;
      shd_sync <= 1'b0;
    end else begin
      shd_meta <= drv_shutdown_in;
      shd_sync <= shd_meta;
    end
  end

  ////////////////////////////////////////////////////////////
  // Register writes
  // Checked write frames update; a driver shutdown also sets the error flag
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      serial_write_counter <= `DGCS_WCOUNT_RST;
    end else if (wr_ok) begin
      // Every checked write counts, mapped or not
      // Reads never touch the counter
      serial_write_counter <= serial_write_counter + 8'h01;
    end
  end

  // Configuration, reset value on reset, low ten bits on a config write
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      global_config_flags <= `DGCS_CONFIG_RST;
    end else if (wr_ok && frame_addr_in == `DGCS_ADDR_CONFIG) begin
      global_config_flags <= frame_wdata_in[9:0];
    end
  end

  // Reply delay code, write only, reads return zero
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reply_delay_config <= `DGCS_DLY_RST;
    end else if (wr_ok && frame_addr_in == `DGCS_ADDR_SLVCF) begin
      reply_delay_config <= frame_wdata_in[`DGCS_DLY_MSB:`DGCS_DLY_LSB];
    end
  end

  // Reset flag raised by any reset
  // Status flags, sticky until the host writes ones
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_latched <= `DGCS_STATUS_RST;
    end else begin
      if (wr_ok && frame_addr_in == `DGCS_ADDR_STATUS && frame_wdata_in[`DGCS_ST_RESET]) begin
        status_latched[`DGCS_ST_RESET] <= 1'b0;
      end
      // Clear blocked while error stands, set wins
      // A clear in the same cycle as a shutdown is lost on purpose
      if (shd_sync) begin
        status_latched[`DGCS_ST_DRV_ERR] <= 1'b1;
      end else if (wr_ok && frame_addr_in == `DGCS_ADDR_STATUS &&
                   frame_wdata_in[`DGCS_ST_DRV_ERR] && !err_sync) begin
        status_latched[`DGCS_ST_DRV_ERR] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Read data, captured on a checked read frame
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_ok) begin
      case (frame_addr_in)
        `DGCS_ADDR_CONFIG: rdata_out <= {22'h000000, global_config_flags};
        `DGCS_ADDR_STATUS: rdata_out <= {29'h00000000, uv_sync, status_latched};
        `DGCS_ADDR_WCOUNT: rdata_out <= {24'h000000, serial_write_counter};
        default: rdata_out <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Reply delay timing
  // All sixteen codes, through dgcs_delay_bits
  always @* begin
    next_delay_bits = dgcs_delay_bits(reply_delay_config);
  end

  // Start at end of read frame
  dgcs_delay_timer #(
    .CW(8)
  ) u_delay (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .bit_tick_in(bit_tick_in),
    .start_in(rd_ok && frame_end_in),
    .bits_in(next_delay_bits),
    .busy_out(reply_wait_out),
    .done_out(reply_go_out)
  );

  ////////////////////////////////////////////////////////////
  // Configuration effects
  // Pins pass the synchronisers above; register fields are already on this clock
  // so they feed the outputs directly
  assign global_config_out = global_config_flags;
  assign standstill_reduce_out = !global_config_flags[`DGCS_GC_PDN_DIS] && pdn_sync;
  assign microstep_res_out = global_config_flags[`DGCS_GC_MSTEP_REG] ? mstep_reg_in : {msb_sync, msa_sync};
  assign step_filter_en_out = global_config_flags[`DGCS_GC_STEP_FILT];
  assign test_route_out = global_config_flags[`DGCS_GC_TEST];
  assign enable_pulldown_out = !global_config_flags[`DGCS_GC_TEST];
  assign test_select_out = global_config_flags[`DGCS_GC_TEST] ? hold_current_in : 2'h0;
  // Undervoltage holds driver off
  // Test mode treats the enable pin as asserted
  assign driver_active_out = (global_config_flags[`DGCS_GC_TEST] || !den_sync) && !uv_sync;
  assign status_out = {uv_sync, status_latched};
  assign write_count_out = serial_write_counter;
endmodule // dgcs_regs

// ---- shared/dgcs_map.vh ----
`ifndef DGCS_MAP_VH
`define DGCS_MAP_VH
// Register offsets
`define DGCS_ADDR_CONFIG 7'h00
`define DGCS_ADDR_STATUS 7'h01
`define DGCS_ADDR_WCOUNT 7'h02
`define DGCS_ADDR_SLVCF 7'h03
// Global config field positions
`define DGCS_GC_PDN_DIS 6
`define DGCS_GC_MSTEP_REG 7
`define DGCS_GC_STEP_FILT 8
`define DGCS_GC_TEST 9
// Status field positions
`define DGCS_ST_RESET 0
`define DGCS_ST_DRV_ERR 1
`define DGCS_ST_PUMP_UV 2
// Reply delay field
`define DGCS_DLY_LSB 8
`define DGCS_DLY_MSB 11
// Reset values
`define DGCS_CONFIG_RST 10'h101
`define DGCS_STATUS_RST 2'h1
`define DGCS_WCOUNT_RST 8'h00
`define DGCS_DLY_RST 4'h0
// Timing
`define DGCS_BITS_PER_UNIT 8
`endif

// ---- testbench/dgcs_chk.sv ----
`timescale 1ns/1ps
// Ties bank outputs to the frames and pins that cause them
module dgcs_chk (
  input wire clk_in,
  input wire resetn_in,
  input wire frame_valid_in,
  input wire frame_write_in,
  input wire frame_end_in,
  input wire drv_shutdown_in,
  input wire [9:0] global_config_out,
  input wire standstill_reduce_out,
  input wire step_filter_en_out,
  input wire test_route_out,
  input wire enable_pulldown_out,
  input wire driver_active_out,
  input wire reply_wait_out,
  input wire [2:0] status_out,
  input wire [7:0] write_count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence wr_s; frame_valid_in && frame_write_in; endsequence
  sequence rd_s; frame_valid_in && !frame_write_in && frame_end_in; endsequence
  pdn_gate_a: assert property (standstill_reduce_out |-> !global_config_out[6]) else $error("pin reduce");
  step_filter_a: assert property (step_filter_en_out == global_config_out[8]) else $error("filter");
  test_pin_a: assert property (test_route_out != enable_pulldown_out) else $error("test pin");
  pump_block_a: assert property (status_out[2] |-> !driver_active_out) else $error("pump uv");
  write_count_a: assert property (wr_s |=> write_count_out == $past(write_count_out) + 8'h01) else $error("count");
  read_keep_a: assert property (rd_s |=> $stable(write_count_out)) else $error("read count");
  reset_flag_a: assert property (status_out[0] && !frame_valid_in |=> status_out[0]) else $error("reset flag");
  shutdown_flag_a: assert property (drv_shutdown_in |-> ##[1:4] status_out[1]) else $error("shutdown");
  reply_start_a: assert property (rd_s |=> reply_wait_out) else $error("reply wait");
endmodule // dgcs_chk
bind dgcs_regs dgcs_chk chk (.clk_in, .resetn_in, .frame_valid_in, .frame_write_in, .frame_end_in, .drv_shutdown_in,
  .global_config_out, .standstill_reduce_out, .step_filter_en_out, .test_route_out, .enable_pulldown_out,
  .driver_active_out, .reply_wait_out, .status_out, .write_count_out);

// ---- testbench/dgcs_host.sv ----
`timescale 1ns/1ps
// Host side of the serial link: bit times and checked frames
module dgcs_host (
  input wire clk_in,
  output logic bit_tick_out,
  output logic frame_valid_out,
  output logic frame_write_out,
  output logic [6:0] frame_addr_out,
  output logic [31:0] frame_wdata_out
);
  logic [1:0] div = 2'h0;
  initial begin
    bit_tick_out = 1'b0;
    frame_valid_out = 1'b0;
    frame_write_out = 1'b0;
    frame_addr_out = 7'h00;
    frame_wdata_out = 32'h0;
  end
  // One bit time every four clocks
  always @(negedge clk_in) begin
    div <= div + 2'h1;
    bit_tick_out <= &div;
  end
  task automatic send(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge clk_in);
    frame_write_out = w;
    frame_addr_out = a;
    frame_wdata_out = d;
    frame_valid_out = 1'b1;
    @(negedge clk_in);
    frame_valid_out = 1'b0;
    frame_wdata_out = ~d;
    @(negedge clk_in);
  endtask
endmodule // dgcs_host

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic clk_in, resetn_in, bit_tick_in, frame_valid_in, frame_write_in, drv_err_cond_in, drv_shutdown_in, pump_uv_in;
  logic pdn_pin_in, microstep_sel_a_in, microstep_sel_b_in, driver_enable_low_in, reply_go_out, reply_wait_out;
  logic standstill_reduce_out, step_filter_en_out, test_route_out, enable_pulldown_out, driver_active_out;
  logic [1:0] mstep_reg_in, hold_current_in, microstep_res_out, test_select_out;
  logic [6:0] frame_addr_in;
  logic [31:0] frame_wdata_in, rdata_out, r;
  logic [9:0] global_config_out;
  logic [2:0] status_out;
  logic [7:0] write_count_out, wc;
  int fail_count, compares, cyc, tk, n;
  dgcs_host host (.clk_in, .bit_tick_out(bit_tick_in), .frame_valid_out(frame_valid_in),
    .frame_write_out(frame_write_in), .frame_addr_out(frame_addr_in), .frame_wdata_out(frame_wdata_in));
  dgcs_regs dut (.clk_in, .resetn_in, .bit_tick_in, .frame_valid_in, .frame_write_in, .frame_addr_in, .frame_wdata_in,
    .frame_end_in(1'b1), .frame_rdata_unused_in(32'h0), .drv_err_cond_in, .drv_shutdown_in, .pump_uv_in, .pdn_pin_in,
    .microstep_sel_a_in, .microstep_sel_b_in, .mstep_reg_in, .hold_current_in, .driver_enable_low_in, .rdata_out,
    .reply_go_out, .reply_wait_out, .global_config_out, .standstill_reduce_out, .microstep_res_out,
    .step_filter_en_out, .test_route_out, .enable_pulldown_out, .test_select_out, .driver_active_out, .status_out,
    .write_count_out);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic int dly_bits(input int c);
    return (2 * (c / 2) + 1) * 8;
  endfunction
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Expected write count, bit times since the last read, hang guard
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) wc <= 8'h00;
    else if (frame_valid_in && frame_write_in) wc <= wc + 8'h01;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    tk <= (frame_valid_in && !frame_write_in) ? 0 : tk + bit_tick_in;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {resetn_in, drv_err_cond_in, drv_shutdown_in, pump_uv_in, pdn_pin_in, microstep_sel_a_in} = 6'h00;
    {microstep_sel_b_in, mstep_reg_in, hold_current_in, driver_enable_low_in} = 6'h01;
    n = $urandom(90);
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    check(global_config_out, 32'h101);
    check(status_out, 32'h1);
    host.send(1'b1, 7'h01, 32'h0);
    check(status_out[0], 1'b1);
    host.send(1'b1, 7'h01, 32'h1);
    check(status_out[0], 1'b0);
    repeat (12) begin
      r = $urandom;
      {pdn_pin_in, mstep_reg_in, hold_current_in, microstep_sel_a_in, microstep_sel_b_in} = 7'($urandom);
      driver_enable_low_in = $urandom;
      host.send(1'b1, 7'h00, r);
      check(global_config_out, r[9:0]);
      check(standstill_reduce_out, !r[6] & pdn_pin_in);
      check(microstep_res_out, r[7] ? mstep_reg_in : {microstep_sel_b_in, microstep_sel_a_in});
      check(test_select_out, r[9] ? hold_current_in : 2'h0);
      check(driver_active_out, r[9] | !driver_enable_low_in);
      check(step_filter_en_out, r[8]);
      check(test_route_out, r[9]);
      check(enable_pulldown_out, !r[9]);
      host.send(1'b0, 7'h00, 32'h0);
      check(rdata_out, r[9:0]);
    end
    pdn_pin_in = 1'b1;
    host.send(1'b1, 7'h00, 32'h41);
    check(standstill_reduce_out, 1'b0);
    check(test_select_out, 2'h0);
    check(step_filter_en_out, 1'b0);
    $display("config test done");
    drv_shutdown_in = 1'b1;
    drv_err_cond_in = 1'b1;
    repeat (4) @(negedge clk_in);
    drv_shutdown_in = 1'b0;
    host.send(1'b1, 7'h01, 32'h2);
    check(status_out[1], 1'b1);
    drv_err_cond_in = 1'b0;
    pump_uv_in = 1'b1;
    repeat (4) @(negedge clk_in);
    host.send(1'b1, 7'h01, 32'h6);
    check(status_out, 32'h4);
    check(driver_active_out, 1'b0);
    pump_uv_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check(status_out[2], 1'b0);
    $display("status test done");
    repeat (260) host.send(1'b1, 7'h7f, $urandom);
    host.send(1'b0, 7'h02, 32'h0);
    check(write_count_out, wc);
    check(rdata_out, {24'h0, wc});
    host.send(1'b0, 7'h7f, 32'h0);
    check(rdata_out, 32'h0);
    for (int c = 0; c < 16; c++) begin
      host.send(1'b1, 7'h03, {20'h0, 4'(c), 8'h00});
      host.send(1'b0, 7'h00, 32'h0);
      n = 0;
      while (!reply_go_out && n < 600) begin
        @(negedge clk_in);
        n++;
      end
      check(tk, dly_bits(c));
    end
    $display("delay test done");
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    check({status_out[0], global_config_out}, 32'h501);
    wrap_up();
  end
endmodule // testbench
